// [hw/jtp_regs.vh]
`ifndef JTP_REGS_VH
`define JTP_REGS_VH
// instruction codes, 4-bit
`define JTP_IR_W          4
`define JTP_DR_W          32
`define JTP_IR_EXTEST     4'h0
`define JTP_IR_SAMPLE     4'h1
`define JTP_IR_DEVICE_IDENTIFICATION     4'h2
`define JTP_IR_USERCODE   4'h3
`define JTP_IR_CHIP       4'h4
`define JTP_IR_PLL        4'h8
`define JTP_IR_BYPASS     4'hf
`define JTP_IR_CAPTURE    4'h1
// identification layout
`define JTP_ID_VER_HI     31
`define JTP_ID_VER_LO     28
`define JTP_ID_PART_HI    27
`define JTP_ID_PART_LO    12
`define JTP_ID_MFR_HI     11
`define JTP_ID_MFR_LO     1
// usercode layout
`define JTP_UC_UID_HI     31
`define JTP_UC_UID_LO     18
`define JTP_UC_REV_HI     17
`define JTP_UC_REV_LO     0
`define JTP_UID_W         14
`define JTP_OTP_UID_ADDR  11'h004
// pll settings bits
`define JTP_PLL_RST_BIT   31
`define JTP_PLL_BOOT_BIT  30
// pll write completion, in tck pulses
`define JTP_PLL_TCKS      8'd100
`define JTP_TMS_RESET_N   3'd5
`endif

// [hw/jtp_tap.v]
// Function
// - single standard tap, 4-bit instruction, 32-bit data register.
// - instruction selects pass-through to the chip-level tap behind.
// - tms high five test clocks forces test-logic-reset.
// - device_identification instruction scans a fixed identification value.
// - usercode instruction scans user identifier and silicon revision.
// - user identifier is otp user word bits 13:0, zero unprogrammed.
// - user identifier loaded by boot after reset release only.
// - instruction eight writes shifted data into pll settings.
// - pll settings hold device reset bit and boot-from-port bit.
// - code loads through the port; port never writes flash or otp.
// - power-on reset holds device reset low until supplies valid.
// - user identifier sits in usercode bits 31 to 18.
// - user word lives at otp word address 0x004.
`timescale 1ns/10ps
`include "jtp_regs.vh"
module jtp_tap #(
  parameter [3:0]  ID_VERSION = 4'h0,   // arbitrary value
  parameter [15:0] ID_PART    = 16'h1234, // arbitrary value
  parameter [10:0] ID_MFR     = 11'h055, // arbitrary value
  parameter [17:0] SI_REV     = 18'h00001
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // jtag pins
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo,
  output reg         tdo_oe,
  // chip-level tap behind
  output reg         chip_tck,
  output reg         chip_tms,
  output reg         chip_tdi,
  input  wire        chip_tdo,
  // boundary scan chain
  output wire        bsc_shift,
  output wire        bsc_capture,
  output wire        bsc_update,
  output wire        bsc_tdi,
  input  wire        bsc_tdo,
  // otp user word and boot
  output reg  [10:0] otp_addr,
  input  wire [31:0] otp_word,
  input  wire        boot_uid_load,
  // supplies, device reset and pll settings
  input  wire        supplies_valid,
  output reg         dev_rst_n,
  output reg  [31:0] pll_settings,
  output reg         pll_wr,
  output reg         boot_from_jtag
);
  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDR = 16'h0004,
                    S_CDR = 16'h0008, S_SHD = 16'h0010, S_E1D = 16'h0020,
                    S_PAD = 16'h0040, S_E2D = 16'h0080, S_UDR = 16'h0100,
                    S_SIR = 16'h0200, S_CIR = 16'h0400, S_SHI = 16'h0800,
                    S_E1I = 16'h1000, S_PAI = 16'h2000, S_E2I = 16'h4000,
                    S_UIR = 16'h8000;
  reg [2:0]  sync_reg [0:2];
  reg        tck_d_reg;
  reg [15:0] st_reg, st_next;
  reg [2:0]  tms_cnt_reg;
  reg [3:0]  ir_sh_reg, ir_reg;
  reg [31:0] dr_reg;
  reg        byp_reg;
  reg [13:0] uid_reg;
  reg [7:0]  pll_cnt_reg;
  reg [31:0] pll_hold_reg;
  reg        pll_pend_reg;
  reg        rst_pll_reg;
  reg        pwr_ok_reg;
  reg [1:0]  pwr_sync_reg;
  integer    i;
  wire tck_s = sync_reg[0][1];
  wire tms_s = sync_reg[1][1];
  wire tdi_s = sync_reg[2][1];
  wire rise  = tck_s & ~tck_d_reg;
  wire fall  = ~tck_s & tck_d_reg;
  wire chip_sel = (ir_reg == `JTP_IR_CHIP);
  wire bsc_sel  = (ir_reg == `JTP_IR_EXTEST) | (ir_reg == `JTP_IR_SAMPLE);
  wire dr_sel   = (ir_reg == `JTP_IR_DEVICE_IDENTIFICATION) | (ir_reg == `JTP_IR_USERCODE) |
                  (ir_reg == `JTP_IR_PLL);
  // two flops per pin input
  always @(posedge core_clk) begin
    for (i = 0; i < 3; i = i + 1)
      sync_reg[i] <= {sync_reg[i][1:0], (i == 0) ? tck : (i == 1) ? tms : tdi};
    tck_d_reg <= tck_s;
  end
  always @* begin
    case (st_reg)
      S_TLR: st_next = tms_s ? S_TLR : S_RTI;
      S_RTI: st_next = tms_s ? S_SDR : S_RTI;
      S_SDR: st_next = tms_s ? S_SIR : S_CDR;
      S_CDR: st_next = tms_s ? S_E1D : S_SHD;
      S_SHD: st_next = tms_s ? S_E1D : S_SHD;
      S_E1D: st_next = tms_s ? S_UDR : S_PAD;
      S_PAD: st_next = tms_s ? S_E2D : S_PAD;
      S_E2D: st_next = tms_s ? S_UDR : S_SHD;
      S_UDR: st_next = tms_s ? S_SDR : S_RTI;
      S_SIR: st_next = tms_s ? S_TLR : S_CIR;
      S_CIR: st_next = tms_s ? S_E1I : S_SHI;
      S_SHI: st_next = tms_s ? S_E1I : S_SHI;
      S_E1I: st_next = tms_s ? S_UIR : S_PAI;
      S_PAI: st_next = tms_s ? S_E2I : S_PAI;
      S_E2I: st_next = tms_s ? S_UIR : S_SHI;
      S_UIR: st_next = tms_s ? S_SDR : S_RTI;
      default: st_next = S_TLR;
    endcase
  end
  // boundary chain and chip tap see the same edges
  assign bsc_shift   = bsc_sel & (st_reg == S_SHD) & rise;
  assign bsc_capture = bsc_sel & (st_reg == S_CDR) & rise;
  assign bsc_update  = bsc_sel & (st_reg == S_UDR) & rise;
  assign bsc_tdi     = tdi_s;
  always @(posedge core_clk) begin
    if (!rstn) begin
      st_reg       <= S_TLR;
      tms_cnt_reg  <= 3'd0;
      ir_sh_reg    <= 4'h0;
      ir_reg       <= `JTP_IR_DEVICE_IDENTIFICATION;
      dr_reg       <= 32'h0;
      byp_reg      <= 1'b0;
      tdo          <= 1'b0;
      tdo_oe       <= 1'b0;
      chip_tck     <= 1'b0;
      chip_tms     <= 1'b1;
      chip_tdi     <= 1'b0;
      pll_cnt_reg  <= 8'd0;
      pll_hold_reg <= 32'h0;
      pll_pend_reg <= 1'b0;
      pll_settings <= 32'h0;
      pll_wr       <= 1'b0;
      rst_pll_reg  <= 1'b0;
      boot_from_jtag <= 1'b0;
    end else begin
      pll_wr   <= 1'b0;
      rst_pll_reg <= 1'b0;
      chip_tck <= chip_sel & tck_s;
      chip_tms <= chip_sel ? tms_s : 1'b1;
      chip_tdi <= tdi_s;
      if (rise) begin
        st_reg <= st_next;
        if (tms_s && tms_cnt_reg == `JTP_TMS_RESET_N - 3'd1) begin
          st_reg <= S_TLR;
          ir_reg <= `JTP_IR_DEVICE_IDENTIFICATION;
        end
        tms_cnt_reg <= !tms_s ? 3'd0 :
                       (tms_cnt_reg == `JTP_TMS_RESET_N - 3'd1) ? 3'd0 :
                       tms_cnt_reg + 3'd1;
        if (st_reg == S_TLR)
          ir_reg <= `JTP_IR_DEVICE_IDENTIFICATION;
        if (st_reg == S_CIR)
          ir_sh_reg <= `JTP_IR_CAPTURE;
        if (st_reg == S_SHI)
          ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]};
        if (st_reg == S_UIR)
          ir_reg <= ir_sh_reg;
        if (st_reg == S_CDR) begin
          byp_reg <= 1'b0;
          case (ir_reg)
            `JTP_IR_DEVICE_IDENTIFICATION:
              dr_reg <= {ID_VERSION, ID_PART, ID_MFR, 1'b1};
            `JTP_IR_USERCODE:
              dr_reg <= {uid_reg, SI_REV};
            `JTP_IR_PLL:
              dr_reg <= pll_settings;
            default:
              dr_reg <= 32'h0;
          endcase
        end
        if (st_reg == S_SHD) begin
          dr_reg  <= {tdi_s, dr_reg[31:1]};
          byp_reg <= tdi_s;
        end
        if (st_reg == S_UDR && ir_reg == `JTP_IR_PLL) begin
          pll_hold_reg <= dr_reg;
          pll_pend_reg <= 1'b1;
          pll_cnt_reg  <= 8'd0;
        end else if (pll_pend_reg) begin
          if (pll_cnt_reg == `JTP_PLL_TCKS - 8'd1) begin
            pll_pend_reg <= 1'b0;
            pll_settings <= pll_hold_reg;
            pll_wr       <= 1'b1;
            rst_pll_reg    <= pll_hold_reg[`JTP_PLL_RST_BIT];
            boot_from_jtag <= pll_hold_reg[`JTP_PLL_BOOT_BIT];
          end else
            pll_cnt_reg <= pll_cnt_reg + 8'd1;
        end
      end
      if (fall) begin
        tdo_oe <= (st_reg == S_SHD) | (st_reg == S_SHI);
        if (st_reg == S_SHI)
          tdo <= ir_sh_reg[0];
        else if (chip_sel)
          tdo <= chip_tdo;
        else if (bsc_sel)
          tdo <= bsc_tdo;
        else if (dr_sel)
          tdo <= dr_reg[0];
        else
          tdo <= byp_reg;
      end
    end
  end
  always @(posedge core_clk) begin
    if (!rstn) begin
      pwr_sync_reg <= 2'b00;
      pwr_ok_reg   <= 1'b0;
      dev_rst_n    <= 1'b0;
    end else begin
      pwr_sync_reg <= {pwr_sync_reg[0], supplies_valid};
      pwr_ok_reg   <= pwr_sync_reg[1];
      dev_rst_n    <= pwr_ok_reg & ~rst_pll_reg;
    end
  end
  // uid from otp after reset release
  always @(posedge core_clk) begin
    if (!rstn) begin
      uid_reg  <= 14'h0;
      otp_addr <= `JTP_OTP_UID_ADDR;
    end else begin
      otp_addr <= `JTP_OTP_UID_ADDR;
      if (!dev_rst_n)
        uid_reg <= 14'h0;
      else if (boot_uid_load)
        uid_reg <= otp_word[`JTP_UID_W-1:0];
    end
  end
endmodule // jtp_tap

// [dv/jtp_props.sv]
`timescale 1ns/10ps
module jtp_props (
  // clock, reset, pins
  input logic        core_clk,
  input logic        rstn,
  input logic        tck,
  input logic        tms,
  input logic        tdo_oe,
  // device side
  input logic [10:0] otp_addr,
  input logic        supplies_valid,
  input logic        dev_rst_n,
  input logic [31:0] pll_settings,
  input logic        pll_wr,
  input logic        boot_from_jtag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic       tck_q;
  logic [2:0] hi_cnt;
  // raw tck leads the design's synced copy, so bounds allow slack
  always @(posedge core_clk) begin
    tck_q <= tck;
    if (!rstn || (tck && !tck_q && !tms)) hi_cnt <= 3'd0;
    else if (tck && !tck_q && hi_cnt != 3'd5) hi_cnt <= hi_cnt + 3'd1;
  end
  // four flops from pin to reset output, so five low samples
  sequence supply_low; !supplies_valid [*5]; endsequence
  sequence supply_ok; supplies_valid [*4]; endsequence
  a_tms_reset: assert property ($rose(hi_cnt == 3'd5) |-> ##[0:8] !tdo_oe)
    else $error("no reset after five tms highs");
  a_shift_exit: assert property (hi_cnt >= 3'd2 |-> !tdo_oe)
    else $error("tdo driven outside shift");
  a_otp_addr: assert property ($past(rstn) |-> otp_addr == 11'h004)
    else $error("wrong otp word address");
  a_supply_hold: assert property (supply_low |-> !dev_rst_n)
    else $error("device reset released early");
  a_rst_pulse: assert property (supply_ok ##1 $fell(dev_rst_n) |-> pll_settings[31] ##1 dev_rst_n)
    else $error("bad device reset pulse");
  a_boot_bit: assert property (pll_wr |-> ##[0:1] boot_from_jtag == pll_settings[30])
    else $error("boot bit not taken");
  a_pll_commit: assert property ($changed(pll_settings) |-> pll_wr)
    else $error("settings changed without write");
  a_wr_pulse: assert property (pll_wr |=> !pll_wr)
    else $error("write pulse too long");
endmodule // jtp_props

// [dv/jtp_host.sv]
`timescale 1ns/10ps
module jtp_host (
  // controller pins
  input  logic core_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input  logic tdo
);
  logic [31:0] rd;
  event        got;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 80 ns tck period; tdo sampled just before the next fall
  task automatic cyc(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(negedge core_clk);
    tck = 1'b1;
    repeat (4) @(negedge core_clk);
    o = tdo;
    // falls here, so tck parks low between frames
    tck = 1'b0;
  endtask
  task automatic shift(input logic ir, input int n, input logic [31:0] v);
    logic o;
    cyc(1'b1, 1'b0, o);
    if (ir) cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, v[i], o);
      rd[i] = o;
    end
    cyc(1'b1, ~v[n-1], o);
    cyc(1'b0, ~v[n-1], o);
  endtask
  task automatic scan(input logic [3:0] ir, input logic [31:0] v);
    shift(1'b1, 4, {28'h0, ir});
    shift(1'b0, 32, v);
    ->got;
  endtask
  // five tms highs, then data scan only
  task automatic rescan(input logic [31:0] v);
    logic o;
    repeat (5) cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    shift(1'b0, 32, v);
    ->got;
  endtask
  // extra pulses to finish the settings write
  task automatic pulses(input int n);
    logic o;
    repeat (n) cyc(1'b0, 1'b0, o);
  endtask
endmodule // jtp_host

// [dv/jtp_tap_tb.sv]
`timescale 1ns/10ps
`include "jtp_regs.vh"
module jtp_tap_tb;
  logic        core_clk = 1'b0, rstn = 1'b0, boot_uid_load = 1'b0, supplies_valid = 1'b0;
  logic        tck, tms, tdi, tdo, chip_tdi, bsc_tdi, pll_wr, boot_from_jtag;
  logic        bsc_shift, bsc_capture, bsc_update;
  logic [23:0] bsc_cnt = 24'h0;
  logic [31:0] otp_word = 32'h0, seed = 32'h83bb, pll_settings, v;
  logic [31:0] q[$];
  int          n_mismatch = 0, checks = 0;
  localparam logic [31:0] ID = {4'h0, 16'h1234, 11'h055, 1'b1};
  localparam logic [17:0] REV = 18'h00001;
  always #5 core_clk = ~core_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  jtp_tap jtp_tap_i (.core_clk, .rstn, .tck, .tms, .tdi, .tdo, .tdo_oe(), .chip_tck(),
    .chip_tms(), .chip_tdi, .chip_tdo(chip_tdi), .bsc_shift, .bsc_capture, .bsc_update,
    .bsc_tdi, .bsc_tdo(bsc_tdi), .otp_addr(), .otp_word, .boot_uid_load, .supplies_valid,
    .dev_rst_n(), .pll_settings, .pll_wr, .boot_from_jtag);
  jtp_host jtp_host_i (.core_clk, .tck, .tms, .tdi, .tdo);
  // chain pulse counts per byte: capture, shift, update
  always @(negedge core_clk)
    if (rstn) bsc_cnt <= bsc_cnt + {7'h0, bsc_capture, 7'h0, bsc_shift, 7'h0, bsc_update};
  always @(posedge core_clk) if (pll_wr) chk("pll", pll_settings, q.pop_front());
  always @(jtp_host_i.got) chk("scan", jtp_host_i.rd, q.pop_front());
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    repeat (20) @(negedge core_clk);
    supplies_valid = 1'b1;
    repeat (8) @(negedge core_clk);
    q.push_back(ID);
    jtp_host_i.rescan(xs());
    q.push_back({14'h0, REV});
    jtp_host_i.scan(`JTP_IR_USERCODE, xs());
    otp_word = xs();
    boot_uid_load = 1'b1;
    @(negedge core_clk);
    boot_uid_load = 1'b0;
    q.push_back({otp_word[13:0], REV});
    jtp_host_i.scan(`JTP_IR_USERCODE, xs());
    v = xs();
    q.push_back({v[30:0], 1'b0});
    jtp_host_i.scan(`JTP_IR_BYPASS, v);
    // sample path through the looped boundary chain
    v = xs();
    q.push_back(v);
    jtp_host_i.scan(`JTP_IR_SAMPLE, v);
    chk("bsc", {8'h0, bsc_cnt}, {8'h0, 8'd1, 8'd32, 8'd1});
    // chip tap path, looped back one core clock late
    v = xs();
    q.push_back({v[30:0], 1'b0});
    jtp_host_i.scan(`JTP_IR_CHIP, v);
    // settings write with reset and boot bits
    v = xs() | 32'hc000_0000;
    q.push_back(32'h0);
    q.push_back(v);
    jtp_host_i.scan(`JTP_IR_PLL, v);
    jtp_host_i.pulses(100);
    repeat (8) @(negedge core_clk);
    chk("boot", {31'h0, boot_from_jtag}, 32'h1);
    q.push_back({14'h0, REV});
    jtp_host_i.scan(`JTP_IR_USERCODE, xs());
    supplies_valid = 1'b0;
    repeat (10) @(negedge core_clk);
    supplies_valid = 1'b1;
    repeat (8) @(negedge core_clk);
    q.push_back(ID);
    jtp_host_i.rescan(xs());
    repeat (8) @(negedge core_clk);
    conclude();
  end
endmodule // jtp_tap_tb
bind jtp_tap jtp_props jtp_props_i (.core_clk, .rstn, .tck, .tms, .tdo_oe, .otp_addr,
  .supplies_valid, .dev_rst_n, .pll_settings, .pll_wr, .boot_from_jtag);
